// ---- rtl/ppfs_pkg.sv ----
// Package of codes and field values for the port pin function select block
package ppfs_pkg;
  // =======================================
  // Serial mode field codes
  localparam logic [2:0] SMD_SYNC = 3'h1;
  localparam logic [2:0] SMD_I2C = 3'h2;
  localparam logic [2:0] SMD_UART7 = 3'h4;
  localparam logic [2:0] SMD_UART8 = 3'h5;
  localparam logic [2:0] SMD_UART9 = 3'h6;
  // =======================================
  // Timer C channel pin routes
  localparam logic [2:0] TC_C_P1_3 = 3'h1;
  localparam logic [2:0] TC_C_P2_1 = 3'h4;
  localparam logic [2:0] TC_C_P3_4 = 3'h2;
  localparam logic [2:0] TC_D_P2_2 = 3'h4;
  localparam logic [2:0] TC_D_P3_5 = 3'h2;
  // =======================================
  // Timer A pin routes and pulse mode
  localparam logic [1:0] TA_P1_5 = 2'h2;
  localparam logic [1:0] TA_P1_7 = 2'h1;
  localparam logic [2:0] TA_MODE_PULSE = 3'h1;
  // =======================================
  // Timer B output modes that produce a waveform
  localparam logic [1:0] TB_MODE_WAVE = 2'h1;
  localparam logic [1:0] TB_MODE_ONE = 2'h2;
  localparam logic [1:0] TB_MODE_WAIT = 2'h3;
  // =======================================
  // Interrupt 1 pin routes
  localparam logic [2:0] IRQ1_P1_7 = 3'h0;
  localparam logic [2:0] IRQ1_P1_5 = 3'h1;
  localparam logic [2:0] IRQ1_P2_0 = 3'h2;
  // =======================================
  // Serial unit 2 receive / transmit pin routes
  localparam logic [1:0] S2_RX_P3_4 = 2'h1;
  localparam logic [1:0] S2_RX_P3_7 = 2'h2;
  localparam logic [1:0] S2_TX_P3_4 = 2'h2;
  localparam logic [1:0] S2_TX_P3_7 = 2'h1;
  // =======================================
  // Pull-up group bit positions
  localparam int PU_P1_LO = 2;
  localparam int PU_P1_HI = 3;
  localparam int PU_P2 = 4;
  localparam int PU_P3_LO = 6;
  localparam int PU_P3_HI = 7;
  // =======================================
  // Reset values
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [7:0] RST_OE_N = 8'hFF;
endpackage

// ---- rtl/ppfs_pin_mux.sv ----
// Pin function multiplexer for port 1, port 2 and port 3 pins
// What this block does
// RULE_01: Unclaimed pin is GPIO input when direction 0, output when direction 1.
// RULE_02: Peripheral output owning a pin drives it regardless of direction bit.
// RULE_03: Group pull-up enabled only when group bit set and pin is input.
// RULE_04: Output pin gets high drive when its drive-strength bit is 1.
// RULE_05: Serial 0 transmit on P1_4 when routed and transmitting; optional open drain.
// RULE_06: Serial 2 transmit, data and I2C clock open drain when its bit set.
// RULE_07: Serial 2 clock on P3_5 when routed; output in sync mode with direction 0, input when direction 1.
// RULE_08: Timer B output on P1_3 or P3_1 by route bit, only in wave modes.
// RULE_09: Timer C channel C to P1_3, P2_1 or P3_4 by select field.
// RULE_10: Timer C channel D to P2_2 or P3_5 by select field.
// RULE_11: Timer A pin on P1_5 or P1_7; pulse output with polarity 0, mode 001.
// RULE_12: Interrupt 1 from selected pin; comparator select moves P1_7 to comparator B1.
// RULE_13: Comparator B1 reference from P1_6 when unrouted, input and select set.
// RULE_14: Serial 0 clock on P1_6: input when direction 1, output in sync mode.
// RULE_15: P3_3 is comparator B3 input or interrupt 3 input by select bit.
// RULE_16: Comparator B3 reference from P3_4 when selected and pin otherwise unused.
// RULE_17: Serial 2 receive pin becomes I2C clock in I2C mode on P3_4 or P3_7.
`timescale 1ns/100ps
module ppfs_pin_mux (
  input wire logic clk,
  input wire logic sys_rst,
  // Port registers
  input wire logic [7:0] port1_data,
  input wire logic [7:0] port1_direction,
  input wire logic [2:0] port2_data,
  input wire logic [2:0] port2_direction,
  input wire logic [7:0] port3_data,
  input wire logic [7:0] port3_direction,
  input wire logic [7:0] pullup_group_ctl,
  input wire logic [7:0] port1_drive_strength,
  input wire logic [2:0] port2_drive_strength,
  input wire logic [7:0] port3_drive_strength,
  input wire logic [3:0] key_input_enable,
  // Serial unit 0
  input wire logic serial0_tx,
  input wire logic serial0_clk_out,
  input wire logic serial0_tx_route,
  input wire logic serial0_clock_route,
  input wire logic serial0_clock_direction,
  input wire logic [2:0] serial0_mode_field,
  input wire logic serial0_open_drain_enable,
  // Serial unit 2
  input wire logic serial2_tx,
  input wire logic serial2_scl_out,
  input wire logic serial2_clk_out,
  input wire logic [1:0] serial2_rx_route,
  input wire logic [1:0] serial2_tx_route,
  input wire logic serial2_clock_route,
  input wire logic serial2_clock_direction,
  input wire logic [2:0] serial2_mode_field,
  input wire logic i2c_mode_bit,
  input wire logic serial2_open_drain_enable,
  input wire logic clock_open_drain,
  // Timers
  input wire logic timer_b_wave_out,
  input wire logic timer_b_out_route,
  input wire logic [1:0] timer_b_op_mode,
  input wire logic timer_c_chan_c_out,
  input wire logic timer_c_chan_c_out_en,
  input wire logic [2:0] timer_c_chan_c_route,
  input wire logic timer_c_chan_d_out,
  input wire logic timer_c_chan_d_out_en,
  input wire logic [2:0] timer_c_chan_d_route,
  input wire logic timer_a_out,
  input wire logic [1:0] timer_a_io_route,
  input wire logic timer_a_polarity_ctl,
  input wire logic [2:0] timer_a_op_mode,
  // Interrupts and comparators
  input wire logic [2:0] irq1_pin_route,
  input wire logic irq1_input_enable,
  input wire logic irq1_comparator_sel,
  input wire logic irq3_input_enable,
  input wire logic irq3_comparator_sel,
  // Pins
  input wire logic [7:0] port1_pin_in,
  input wire logic [2:0] port2_pin_in,
  input wire logic [7:0] port3_pin_in,
  output logic [7:0] port1_pin_out,
  output logic [7:0] port1_pin_oe_n,
  output logic [7:0] port1_pullup,
  output logic [7:0] port1_high_drive,
  output logic [2:0] port2_pin_out,
  output logic [2:0] port2_pin_oe_n,
  output logic [2:0] port2_pullup,
  output logic [2:0] port2_high_drive,
  output logic [7:0] port3_pin_out,
  output logic [7:0] port3_pin_oe_n,
  output logic [7:0] port3_pullup,
  output logic [7:0] port3_high_drive,
  // Towards peripherals
  output logic [3:0] key_in,
  output logic serial0_clk_in,
  output logic serial2_rx_in,
  output logic serial2_scl_in,
  output logic serial2_sda_in,
  output logic serial2_clk_in,
  output logic timer_a_in,
  output logic timer_c_chan_c_in,
  output logic timer_c_chan_d_in,
  output logic irq1_in,
  output logic irq3_in,
  output logic comparator_b1_input,
  output logic comparator_b1_reference,
  output logic comparator_b3_input,
  output logic comparator_b3_reference
);

  // =======================================
  // Mode decode
  function automatic logic is_tx_mode(input logic [2:0] m);
    is_tx_mode = (m == ppfs_pkg::SMD_SYNC) || (m == ppfs_pkg::SMD_UART7) ||
                 (m == ppfs_pkg::SMD_UART8) || (m == ppfs_pkg::SMD_UART9);
  endfunction

  logic s0_tx_on, s0_clk_out_on, s0_clk_in_on, s2_i2c, s2_tx34, s2_tx37;
  logic s2_scl34, s2_scl37, s2_clk_out_on, tb_active, ta_pulse;
  logic tc_c13, tc_c21, tc_c34, tc_d22, tc_d35;

  always_comb begin
    // RULE_05 Serial 0 transmit enable
    s0_tx_on = serial0_tx_route && is_tx_mode(serial0_mode_field);
    // RULE_14 Serial 0 clock direction
    s0_clk_out_on = serial0_clock_route && !serial0_clock_direction &&
                    (serial0_mode_field == ppfs_pkg::SMD_SYNC);
    s0_clk_in_on = serial0_clock_route && serial0_clock_direction;
    s2_i2c = (serial2_mode_field == ppfs_pkg::SMD_I2C) && i2c_mode_bit;
    s2_tx34 = (serial2_tx_route == ppfs_pkg::S2_TX_P3_4) &&
              (is_tx_mode(serial2_mode_field) || s2_i2c);
    s2_tx37 = (serial2_tx_route == ppfs_pkg::S2_TX_P3_7) &&
              (is_tx_mode(serial2_mode_field) || s2_i2c);
    // RULE_17 I2C clock on the receive pin
    s2_scl34 = s2_i2c && (serial2_rx_route == ppfs_pkg::S2_RX_P3_4);
    s2_scl37 = s2_i2c && (serial2_rx_route == ppfs_pkg::S2_RX_P3_7);
    // RULE_07 Serial 2 clock output
    s2_clk_out_on = serial2_clock_route && !serial2_clock_direction &&
                    (serial2_mode_field == ppfs_pkg::SMD_SYNC);
    // RULE_08 Timer B drives only in waveform modes
    tb_active = (timer_b_op_mode == ppfs_pkg::TB_MODE_WAVE) ||
                (timer_b_op_mode == ppfs_pkg::TB_MODE_ONE) ||
                (timer_b_op_mode == ppfs_pkg::TB_MODE_WAIT);
    // RULE_11 Timer A pulse output
    ta_pulse = !timer_a_polarity_ctl && (timer_a_op_mode == ppfs_pkg::TA_MODE_PULSE);
    // RULE_09 Timer C channel C routes
    tc_c13 = timer_c_chan_c_route == ppfs_pkg::TC_C_P1_3;
    tc_c21 = timer_c_chan_c_route == ppfs_pkg::TC_C_P2_1;
    tc_c34 = timer_c_chan_c_route == ppfs_pkg::TC_C_P3_4;
    // RULE_10 Timer C channel D routes
    tc_d22 = timer_c_chan_d_route == ppfs_pkg::TC_D_P2_2;
    tc_d35 = timer_c_chan_d_route == ppfs_pkg::TC_D_P3_5;
  end

  // =======================================
  // Per-pin ownership: own = peripheral drives, val = level, od = open drain
  logic [7:0] own1, val1, od1, own3, val3, od3;
  logic [2:0] own2, val2;

  always_comb begin
    own1 = 8'h00;
    val1 = 8'h00;
    od1 = 8'h00;
    own2 = 3'h0;
    val2 = 3'h0;
    own3 = 8'h00;
    val3 = 8'h00;
    od3 = 8'h00;
    // RULE_08 Timer B takes P1_3 ahead of timer C
    if (!timer_b_out_route && tb_active) begin
      own1[3] = 1'b1;
      val1[3] = timer_b_wave_out;
    end else if (tc_c13 && timer_c_chan_c_out_en) begin
      own1[3] = 1'b1;
      val1[3] = timer_c_chan_c_out;
    end
    // RULE_05 Transmit on P1_4
    own1[4] = s0_tx_on;
    val1[4] = serial0_tx;
    od1[4] = serial0_open_drain_enable;
    // RULE_11 Timer A pulse on P1_5 or P1_7
    own1[5] = (timer_a_io_route == ppfs_pkg::TA_P1_5) && ta_pulse;
    val1[5] = timer_a_out;
    own1[7] = (timer_a_io_route == ppfs_pkg::TA_P1_7) && ta_pulse;
    val1[7] = timer_a_out;
    // RULE_14 Internal serial clock out on P1_6
    own1[6] = s0_clk_out_on;
    val1[6] = serial0_clk_out;
    // RULE_09 Channel C on P2_1
    own2[1] = tc_c21 && timer_c_chan_c_out_en;
    val2[1] = timer_c_chan_c_out;
    // RULE_10 Channel D on P2_2
    own2[2] = tc_d22 && timer_c_chan_d_out_en;
    val2[2] = timer_c_chan_d_out;
    // RULE_08 Timer B on P3_1
    own3[1] = timer_b_out_route && tb_active;
    val3[1] = timer_b_wave_out;
    // RULE_06 Serial 2 pins share the unit-2 open-drain bit
    if (s2_scl34) begin
      own3[4] = 1'b1;
      val3[4] = serial2_scl_out;
      od3[4] = serial2_open_drain_enable;
    end else if (s2_tx34) begin
      own3[4] = 1'b1;
      val3[4] = serial2_tx;
      od3[4] = serial2_open_drain_enable;
    end else if (tc_c34 && timer_c_chan_c_out_en) begin
      own3[4] = 1'b1;
      val3[4] = timer_c_chan_c_out;
    end
    // RULE_07 Serial 2 clock with its own open-drain bit
    if (s2_clk_out_on) begin
      own3[5] = 1'b1;
      val3[5] = serial2_clk_out;
      od3[5] = clock_open_drain;
    end else if (tc_d35 && timer_c_chan_d_out_en) begin
      own3[5] = 1'b1;
      val3[5] = timer_c_chan_d_out;
    end
    if (s2_scl37) begin
      own3[7] = 1'b1;
      val3[7] = serial2_scl_out;
      od3[7] = serial2_open_drain_enable;
    end else if (s2_tx37) begin
      own3[7] = 1'b1;
      val3[7] = serial2_tx;
      od3[7] = serial2_open_drain_enable;
    end
  end

  // =======================================
  // Pin drivers; open drain releases the pin for a high level
  logic [7:0] next_out1, next_oe1, next_out3, next_oe3;
  logic [2:0] next_out2, next_oe2;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // RULE_02 Peripheral wins over the direction bit
      if (own1[i]) begin
        next_out1[i] = od1[i] ? 1'b0 : val1[i];
        next_oe1[i] = od1[i] ? val1[i] : 1'b0;
      end else begin
        // RULE_01 Plain port behaviour
        next_out1[i] = port1_data[i];
        next_oe1[i] = !port1_direction[i];
      end
      if (own3[i]) begin
        next_out3[i] = od3[i] ? 1'b0 : val3[i];
        next_oe3[i] = od3[i] ? val3[i] : 1'b0;
      end else begin
        next_out3[i] = port3_data[i];
        next_oe3[i] = !port3_direction[i];
      end
    end
    for (int i = 0; i < 3; i++) begin
      next_out2[i] = own2[i] ? val2[i] : port2_data[i];
      next_oe2[i] = own2[i] ? 1'b0 : !port2_direction[i];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port1_pin_out <= ppfs_pkg::RST_OUT;
      port1_pin_oe_n <= ppfs_pkg::RST_OE_N;
      port2_pin_out <= ppfs_pkg::RST_OUT[2:0];
      port2_pin_oe_n <= ppfs_pkg::RST_OE_N[2:0];
      port3_pin_out <= ppfs_pkg::RST_OUT;
      port3_pin_oe_n <= ppfs_pkg::RST_OE_N;
    end else begin
      port1_pin_out <= next_out1;
      port1_pin_oe_n <= next_oe1;
      port2_pin_out <= next_out2;
      port2_pin_oe_n <= next_oe2;
      port3_pin_out <= next_out3;
      port3_pin_oe_n <= next_oe3;
    end
  end

  // =======================================
  // Pull-ups and drive strength
  logic [7:0] pu1, pu3;

  always_comb begin
    pu1 = {{4{pullup_group_ctl[ppfs_pkg::PU_P1_HI]}}, {4{pullup_group_ctl[ppfs_pkg::PU_P1_LO]}}};
    pu3 = {{4{pullup_group_ctl[ppfs_pkg::PU_P3_HI]}}, {4{pullup_group_ctl[ppfs_pkg::PU_P3_LO]}}};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port1_pullup <= ppfs_pkg::RST_OUT;
      port2_pullup <= ppfs_pkg::RST_OUT[2:0];
      port3_pullup <= ppfs_pkg::RST_OUT;
      port1_high_drive <= ppfs_pkg::RST_OUT;
      port2_high_drive <= ppfs_pkg::RST_OUT[2:0];
      port3_high_drive <= ppfs_pkg::RST_OUT;
    end else begin
      // RULE_03 Pull-up only while not driven
      port1_pullup <= pu1 & next_oe1;
      port2_pullup <= {3{pullup_group_ctl[ppfs_pkg::PU_P2]}} & next_oe2;
      port3_pullup <= pu3 & next_oe3;
      // RULE_04 High drive only on driven pins
      port1_high_drive <= port1_drive_strength & ~next_oe1;
      port2_high_drive <= port2_drive_strength & ~next_oe2;
      port3_high_drive <= port3_drive_strength & ~next_oe3;
    end
  end

  // =======================================
  // Inputs towards peripherals
  logic irq1_pin;

  always_comb begin
    case (irq1_pin_route)
      ppfs_pkg::IRQ1_P1_7: irq1_pin = port1_pin_in[7];
      ppfs_pkg::IRQ1_P1_5: irq1_pin = port1_pin_in[5];
      ppfs_pkg::IRQ1_P2_0: irq1_pin = port2_pin_in[0];
      default: irq1_pin = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_in <= 4'h0;
      serial0_clk_in <= 1'b0;
      serial2_rx_in <= 1'b1;
      serial2_scl_in <= 1'b1;
      serial2_sda_in <= 1'b1;
      serial2_clk_in <= 1'b0;
      timer_a_in <= 1'b0;
      timer_c_chan_c_in <= 1'b0;
      timer_c_chan_d_in <= 1'b0;
      irq1_in <= 1'b0;
      irq3_in <= 1'b0;
    end else begin
      // Keys are read only while the pin is an input
      key_in <= port1_pin_in[3:0] & key_input_enable & ~port1_direction[3:0];
      // RULE_14 External clock taken from P1_6
      serial0_clk_in <= s0_clk_in_on ? port1_pin_in[6] : 1'b0;
      serial2_rx_in <= (serial2_rx_route == ppfs_pkg::S2_RX_P3_4) ? port3_pin_in[4] :
                       (serial2_rx_route == ppfs_pkg::S2_RX_P3_7) ? port3_pin_in[7] : 1'b1;
      // RULE_17 Clock sensed back from the receive pin
      serial2_scl_in <= s2_scl34 ? port3_pin_in[4] : s2_scl37 ? port3_pin_in[7] : 1'b1;
      serial2_sda_in <= s2_tx34 ? port3_pin_in[4] : s2_tx37 ? port3_pin_in[7] : 1'b1;
      // RULE_07 Serial 2 clock input
      serial2_clk_in <= (serial2_clock_route && serial2_clock_direction) ? port3_pin_in[5] : 1'b0;
      timer_a_in <= (timer_a_io_route == ppfs_pkg::TA_P1_5) ? port1_pin_in[5] :
                    (timer_a_io_route == ppfs_pkg::TA_P1_7) ? port1_pin_in[7] : 1'b0;
      timer_c_chan_c_in <= tc_c13 ? port1_pin_in[3] : tc_c21 ? port2_pin_in[1] :
                           tc_c34 ? port3_pin_in[4] : 1'b0;
      timer_c_chan_d_in <= tc_d22 ? port2_pin_in[2] : tc_d35 ? port3_pin_in[5] : 1'b0;
      // RULE_12 Interrupt 1 when not claimed by the comparator
      irq1_in <= irq1_input_enable && !irq1_comparator_sel && irq1_pin;
      // RULE_15 Interrupt 3 on P3_3
      irq3_in <= irq3_input_enable && !irq3_comparator_sel && port3_pin_in[3];
    end
  end

  // Analog switch enables for the comparator inputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      comparator_b1_input <= 1'b0;
      comparator_b1_reference <= 1'b0;
      comparator_b3_input <= 1'b0;
      comparator_b3_reference <= 1'b0;
    end else begin
      // RULE_12 P1_7 as comparator B1 input
      comparator_b1_input <= irq1_input_enable && irq1_comparator_sel;
      // RULE_13 P1_6 as comparator B1 reference
      comparator_b1_reference <= !serial0_clock_route && !port1_direction[6] &&
                                 irq1_comparator_sel;
      // RULE_15 P3_3 as comparator B3 input
      comparator_b3_input <= irq3_input_enable && irq3_comparator_sel;
      // RULE_16 Reference only when P3_4 is otherwise free
      comparator_b3_reference <= irq3_comparator_sel && !tc_c34 && !port3_direction[4] &&
                                 (serial2_rx_route != ppfs_pkg::S2_RX_P3_4) &&
                                 (serial2_tx_route != ppfs_pkg::S2_TX_P3_4);
    end
  end

  // =======================================
  // Checks
  sequence s_tx0_sel;
    s0_tx_on && !serial0_open_drain_enable;
  endsequence

  chk_gpio_idle: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    !own1[0] && port1_direction[0] |=> !port1_pin_oe_n[0] &&
    port1_pin_out[0] == $past(port1_data[0]))
    else $error("gpio output not driven");
  chk_tx0_pin: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    s_tx0_sel |=> !port1_pin_oe_n[4] && port1_pin_out[4] == $past(serial0_tx))
    else $error("serial 0 transmit not on pin");
  chk_owner_dir: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
    own2[1] && !port2_direction[1] |=> !port2_pin_oe_n[1])
    else $error("peripheral output blocked by direction");
  chk_pullup_input: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    port3_pullup[7] |-> port3_pin_oe_n[7])
    else $error("pull-up on driven pin");
  chk_drive_bit: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    !port1_pin_oe_n[7] && !$past(port1_drive_strength[7]) |-> !port1_high_drive[7])
    else $error("high drive without its bit");
  chk_tb_route: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    timer_b_out_route && tb_active |=> !port3_pin_oe_n[1] &&
    port3_pin_out[1] == $past(timer_b_wave_out))
    else $error("timer B missing on P3_1");
  chk_od_release: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    s2_tx37 && !s2_scl37 && serial2_open_drain_enable |=> !port3_pin_out[7])
    else $error("open drain pin driven high");
  chk_irq1_mask: assert property (@(posedge clk) disable iff (sys_rst) // RULE_12
    irq1_comparator_sel |=> !irq1_in && comparator_b1_input == $past(irq1_input_enable))
    else $error("interrupt 1 not moved to comparator");
  chk_serial0_clock_pin_in: assert property (@(posedge clk) disable iff (sys_rst) // RULE_14
    !serial0_clock_route |=> !serial0_clk_in)
    else $error("serial 0 clock input leaked");

endmodule

// ---- verif/ppfs_periph_model.sv ----
// Behavioural model of the on-chip peripherals that feed the pin multiplexer
`timescale 1ns/100ps
module ppfs_periph_model (
  input wire logic lvl,
  input wire logic tc_en,
  output logic serial0_tx,
  output logic serial0_clk_out,
  output logic serial2_tx,
  output logic serial2_scl_out,
  output logic serial2_clk_out,
  output logic timer_b_wave_out,
  output logic timer_c_chan_c_out,
  output logic timer_c_chan_c_out_en,
  output logic timer_c_chan_d_out,
  output logic timer_c_chan_d_out_en,
  output logic timer_a_out
);
  // =======================================
  // Unit outputs
  // Clocks run opposite to data, so a clock routed in place of data is seen
  assign serial0_tx = lvl;
  assign serial0_clk_out = ~lvl;
  assign serial2_tx = lvl;
  assign serial2_scl_out = ~lvl;
  assign serial2_clk_out = ~lvl;
  assign timer_b_wave_out = lvl;
  assign timer_c_chan_c_out = lvl;
  assign timer_c_chan_d_out = lvl;
  assign timer_a_out = lvl;
  // Timer C pin modes live in the timer, so only its enable is modelled
  assign timer_c_chan_c_out_en = tc_en;
  assign timer_c_chan_d_out_en = tc_en;
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the port pin function multiplexer
`timescale 1ns/100ps
module tb_top;
  // =======================================
  // Stimulus and observed signals
  logic clk = '0, sys_rst = '1, lvl = '0, tc_en = '0;
  logic [7:0] port1_data = '0, port1_direction = '0, port3_data = '0, port3_direction = '0;
  logic [7:0] pullup_group_ctl = '0, port1_drive_strength = '0, port3_drive_strength = '0;
  logic [7:0] port1_pin_in = '0, port3_pin_in = '0;
  logic [2:0] port2_data = '0, port2_direction = '0, port2_drive_strength = '0;
  logic [2:0] port2_pin_in = '0, serial0_mode_field = '0, serial2_mode_field = '0;
  logic [2:0] timer_c_chan_c_route = '0, timer_c_chan_d_route = '0, timer_a_op_mode = '0;
  logic [2:0] irq1_pin_route = '0;
  logic [3:0] key_input_enable = '0;
  logic [1:0] serial2_rx_route = '0, serial2_tx_route = '0, timer_b_op_mode = '0;
  logic [1:0] timer_a_io_route = '0;
  logic serial0_tx_route = '0, serial0_clock_route = '0, serial0_clock_direction = '0;
  logic serial0_open_drain_enable = '0, serial2_clock_route = '0, serial2_clock_direction = '0;
  logic i2c_mode_bit = '0, serial2_open_drain_enable = '0, clock_open_drain = '0;
  logic timer_b_out_route = '0, timer_a_polarity_ctl = '0, irq1_input_enable = '0;
  logic irq1_comparator_sel = '0, irq3_input_enable = '0, irq3_comparator_sel = '0;
  logic serial0_tx, serial0_clk_out, serial2_tx, serial2_scl_out, serial2_clk_out;
  logic timer_b_wave_out, timer_c_chan_c_out, timer_c_chan_c_out_en, timer_c_chan_d_out;
  logic timer_c_chan_d_out_en, timer_a_out;
  logic [7:0] port1_pin_out, port1_pin_oe_n, port1_pullup, port1_high_drive;
  logic [7:0] port3_pin_out, port3_pin_oe_n, port3_pullup, port3_high_drive;
  logic [2:0] port2_pin_out, port2_pin_oe_n, port2_pullup, port2_high_drive;
  logic [3:0] key_in;
  logic serial0_clk_in, serial2_rx_in, serial2_scl_in, serial2_sda_in, serial2_clk_in;
  logic timer_a_in, timer_c_chan_c_in, timer_c_chan_d_in, irq1_in, irq3_in;
  logic comparator_b1_input, comparator_b1_reference, comparator_b3_input;
  logic comparator_b3_reference;
  int n_errors = 0;
  int n_compared = 0;

  ppfs_pin_mux dut (.*);
  ppfs_periph_model peri (.*);

  initial forever #20 clk = ~clk;

  // =======================================
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask

  // Outputs are one flop behind: sample at the following falling edge
  task automatic step;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic results;
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // =======================================
  // Scenarios
  // plain port pins
  task automatic t_gpio;
    port1_direction = 8'hF0;
    port1_data = 8'hA5;
    pullup_group_ctl = 8'h04;
    key_input_enable = 4'hF;
    port1_pin_in = 8'h05;
    step();
    chk("p1_oe_n", 8'h0F, port1_pin_oe_n);
    chk("p1_out", 8'hA0, port1_pin_out & 8'hF0);
    chk("key_in", 8'h05, 8'(key_in));
    chk("p1_pullup", 8'h0F, port1_pullup);
    port1_direction = 8'h00;
    pullup_group_ctl = 8'h0C;
    step();
    chk("p1_pullup_all", 8'hFF, port1_pullup);
  endtask

  task automatic t_tx0;
    logic [2:0] md [4] = '{ppfs_pkg::SMD_SYNC, ppfs_pkg::SMD_UART7, ppfs_pkg::SMD_UART8,
      ppfs_pkg::SMD_UART9};
    serial0_tx_route = 1'b1;
    lvl = 1'b1;
    foreach (md[i]) begin
      serial0_mode_field = md[i];
      step();
      chk("tx0_oe_n", 8'h00, 8'(port1_pin_oe_n[4]));
      chk("tx0_out", 8'h01, 8'(port1_pin_out[4]));
    end
    serial0_open_drain_enable = 1'b1;
    lvl = 1'b0;
    step();
    chk("od_low", 8'h00, 8'(port1_pin_oe_n[4]));
    lvl = 1'b1;
    step();
    chk("od_release", 8'h01, 8'(port1_pin_oe_n[4]));
    chk("od_pullup", 8'h01, 8'(port1_pullup[4]));
  endtask

  task automatic t_tmrb;
    port3_direction = 8'h00;
    for (int k = 0; k < 8; k++) begin
      timer_b_op_mode = k[1:0];
      timer_b_out_route = k[2];
      step();
      chk("tb_p1_3", 8'(!(k[1:0] != 0 && !k[2])), 8'(port1_pin_oe_n[3]));
      chk("tb_p3_1", 8'(!(k[1:0] != 0 && k[2])), 8'(port3_pin_oe_n[1]));
    end
  endtask

  // timer C channel routes, every select code
  task automatic t_tmrc;
    tc_en = 1'b1;
    for (int r = 0; r < 8; r++) begin
      timer_c_chan_c_route = r[2:0];
      timer_c_chan_d_route = r[2:0];
      step();
      chk("tcc_p1_3", 8'(r != 1), 8'(port1_pin_oe_n[3]));
      chk("tcc_p2_1", 8'(r != 4), 8'(port2_pin_oe_n[1]));
      chk("tcc_p3_4", 8'(r != 2), 8'(port3_pin_oe_n[4]));
      chk("tcd_p2_2", 8'(r != 4), 8'(port2_pin_oe_n[2]));
      chk("tcd_p3_5", 8'(r != 2), 8'(port3_pin_oe_n[5]));
    end
  endtask

  task automatic t_cmp;
    port1_pin_in = 8'h80;
    port3_pin_in = 8'h08;
    irq1_input_enable = 1'b1;
    irq3_input_enable = 1'b1;
    irq1_pin_route = ppfs_pkg::IRQ1_P1_7;
    for (int s = 0; s < 2; s++) begin
      irq1_comparator_sel = s[0];
      irq3_comparator_sel = s[0];
      step();
      chk("irq1", 8'(s == 0), 8'(irq1_in));
      chk("cmp_b1_in", 8'(s == 1), 8'(comparator_b1_input));
      chk("cmp_b1_ref", 8'(s == 1), 8'(comparator_b1_reference));
      chk("irq3", 8'(s == 0), 8'(irq3_in));
      chk("cmp_b3_in", 8'(s == 1), 8'(comparator_b3_input));
      chk("cmp_b3_ref", 8'(s == 1), 8'(comparator_b3_reference));
    end
  endtask

  // serial 2 pins on port 3
  task automatic t_ser2;
    serial2_mode_field = ppfs_pkg::SMD_I2C;
    i2c_mode_bit = 1'b1;
    serial2_rx_route = ppfs_pkg::S2_RX_P3_4;
    serial2_tx_route = ppfs_pkg::S2_TX_P3_7;
    serial2_open_drain_enable = 1'b1;
    lvl = 1'b0;
    port3_pin_in = 8'h10;
    step();
    chk("s2_od_oe_n", 8'h10, port3_pin_oe_n & 8'h90);
    chk("serial2_i2c_clock_pin_in", 8'h01, 8'(serial2_scl_in));
    serial2_mode_field = ppfs_pkg::SMD_SYNC;
    serial2_clock_route = 1'b1;
    clock_open_drain = 1'b1;
    step();
    chk("serial2_clock_pin_od", 8'h02, 8'({port3_pin_oe_n[5], port3_pin_out[5]}));
    serial2_clock_direction = 1'b1;
    port3_pin_in = 8'h20;
    step();
    chk("serial2_clock_pin_in", 8'h03, 8'({port3_pin_oe_n[5], serial2_clk_in}));
    serial2_mode_field = 3'h0;
    lvl = 1'b1;
  endtask

  // timer A and serial 0 clock on port 1
  task automatic t_tmra;
    timer_a_io_route = ppfs_pkg::TA_P1_5;
    timer_a_op_mode = ppfs_pkg::TA_MODE_PULSE;
    step();
    chk("ta_pulse", 8'h01, 8'({port1_pin_oe_n[5], port1_pin_out[5]}));
    timer_a_polarity_ctl = 1'b1;
    serial0_clock_route = 1'b1;
    serial0_clock_direction = 1'b1;
    port1_pin_in = 8'h60;
    step();
    chk("ta_in", 8'h03, 8'({port1_pin_oe_n[5], timer_a_in}));
    chk("serial0_clock_pin_in", 8'h01, 8'(serial0_clk_in));
    serial0_clock_direction = 1'b0;
    serial0_mode_field = ppfs_pkg::SMD_SYNC;
    lvl = 1'b0;
    step();
    chk("serial0_clock_pin_out", 8'h01, 8'({port1_pin_oe_n[6], port1_pin_out[6]}));
    serial0_clock_route = 1'b0;
    timer_a_io_route = 2'h0;
    lvl = 1'b1;
  endtask

  // high drive only on driven pins
  task automatic t_drive;
    port1_direction = 8'h0F;
    port1_drive_strength = 8'hFF;
    port3_direction = 8'hFF;
    port3_drive_strength = 8'h81;
    repeat (2) step();
    chk("p1_hd", 8'h0F, port1_high_drive);
    chk("p3_hd", 8'h81, port3_high_drive);
  endtask

  // =======================================
  // Main sequence and watchdog
  initial begin
    repeat (20) @(negedge clk);
    chk("rst_oe_n", ppfs_pkg::RST_OE_N, port1_pin_oe_n);
    chk("rst_out", ppfs_pkg::RST_OUT, port3_pin_out);
    sys_rst = 1'b0;
    t_gpio();
    t_tx0();
    t_tmrb();
    t_tmrc();
    t_cmp();
    t_ser2();
    t_tmra();
    t_drive();
    results();
  end

  // About 50 cycles of tests; far beyond that means a hang
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule
